/* test/tb_vofr_top.sv */
// Self-checking bench of the output-voltage fault supervisor.
// Assumes a 10 MHz clock and short fault time units of 2 cycles.
`timescale 1ns/10ps
`default_nettype none

module tb_vofr_top;
  import vofr_pkg::*;
  logic        clk_sys, rstn, cmdValid, cmdWrite, cmdAck, cmdErr, e;
  logic        outEnableReq, rampActive, ovDetect, outEnable, ovFault;
  logic        uvFault;
  logic [1:0]  cmdLen;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWrData, rdData, voutSample, strapVout, lim, v;
  logic [15:0] rdExp[$];
  logic [31:0] seed = 32'd53604;
  logic [7:0]  acts[2] = '{8'h80, 8'h00};
  int          err_total, n_checks, ups;

  // ==========================================================
  // Clock and units
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  vofr_host u_host (.clk_sys(clk_sys), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdLen(cmdLen), .cmdCode(cmdCode),
    .cmdWrData(cmdWrData), .cmdAck(cmdAck), .cmdErr(cmdErr));
  vofr_top #(.OV_UNIT(2), .UV_UNIT(2)) u_dut (.clk_sys(clk_sys),
    .rstn(rstn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdLen(cmdLen), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
    .cmdAck(cmdAck), .cmdErr(cmdErr), .rdData(rdData),
    .outEnableReq(outEnableReq), .rampActive(rampActive),
    .ovDetect(ovDetect), .voutSample(voutSample),
    .strapVout(strapVout), .outEnable(outEnable), .ovFault(ovFault),
    .uvFault(uvFault));

  // ==========================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task wrap_up();
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task wr(input logic [7:0] c, input logic [1:0] l, input logic [15:0] d,
          input logic xe);
    u_host.issue(1'b1, l, c, d, e);
    chk_flag(e, xe);
  endtask : wr
  // Legal reads leave a note for the watcher
  task rd(input logic [7:0] c, input logic [1:0] l, input logic [15:0] x,
          input logic xe);
    if (!xe) rdExp.push_back(x);
    u_host.issue(1'b0, l, c, 16'h0000, e);
    chk_flag(e, xe);
  endtask : rd
  task clr();
    wr(CMD_CLEAR_FAULTS, LEN_SEND, 16'h0000, 1'b0);
  endtask : clr
  // Bounded wait for the enable to reach a level
  task until_en(input logic lvl, input int n);
    for (int i = 0; i < n; i++) begin
      if (outEnable === lvl) return;
      step(1);
    end
    chk_flag(outEnable, lvl);
    // A wait that ran out ends the run
    if (outEnable !== lvl) wrap_up();
  endtask : until_en
  task watch(input int n);
    logic p;
    ups = 0;
    repeat (n) begin
      p = outEnable;
      step(1);
      if (p === 1'b0 && outEnable === 1'b1) ups++;
    end
  endtask : watch
  // Restart: dropping the request clears engines and retry counts
  task restart();
    ovDetect = 1'b0;
    outEnableReq = 1'b0;
    step(2);
    outEnableReq = 1'b1;
    until_en(1'b1, 20);
  endtask : restart

  // ==========================================================
  // Read-data watcher: a legal read answers one cycle later
  always @(posedge clk_sys) begin : mon
    logic took;
    took = rstn && cmdValid && !cmdWrite && cmdErr === 1'b0;
    #2;
    if (took && rdExp.size() == 0) chk_flag(1'b1, 1'b0);
    else if (took) chk_val(rdData, rdExp.pop_front());
  end

  // Hang guard
  initial begin
    #5000000;
    err_total++;
    $display("mismatch at %0t: run timed out", $time);
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    outEnableReq = 1'b0;
    rampActive = 1'b0;
    ovDetect = 1'b0;
    voutSample = 16'hffff;
    strapVout = 16'(rnd());
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    step(1);
    rd(CMD_OV_ACTION, LEN_BYTE, 16'h0080, 1'b0);
    rd(CMD_UV_ACTION, LEN_BYTE, 16'h0080, 1'b0);
    rd(CMD_UV_LIMIT, LEN_WORD, 16'((32'(strapVout) * 4) / 5), 1'b0);
    lim = 16'(rnd()) | 16'h0100;
    v = 16'(rnd()) & 16'h00ff;
    wr(CMD_UV_LIMIT, LEN_WORD, lim, 1'b0);
    rd(CMD_UV_LIMIT, LEN_WORD, lim, 1'b0);
    wr(CMD_UV_ACTION, LEN_BYTE, v, 1'b0);
    rd(CMD_UV_ACTION, LEN_BYTE, v, 1'b0);
    wr(CMD_OV_ACTION, LEN_WORD, 16'h00c0, 1'b1);
    rd(CMD_OV_ACTION, LEN_BYTE, 16'h0080, 1'b0);
    wr(CMD_UV_LIMIT, LEN_BYTE, 16'h0000, 1'b1);
    rd(CMD_CLEAR_FAULTS, LEN_BYTE, 16'h0000, 1'b1);
    wr(CMD_UV_ACTION, LEN_BYTE, 16'h0000, 1'b0);
    restart();
    // Disable without retry, then ignore code that must act the same
    for (int k = 0; k < 2; k++) begin
      wr(CMD_OV_ACTION, LEN_BYTE, {8'h00, acts[k]}, 1'b0);
      rd(CMD_OV_ACTION, LEN_BYTE, {8'h00, acts[k]}, 1'b0);
      ovDetect = 1'b1;
      step(2);
      chk_flag(outEnable, 1'b0);
      ovDetect = 1'b0;
      step(20);
      chk_flag(outEnable, 1'b0);
      chk_flag(ovFault, 1'b1);
      clr();
      chk_flag(ovFault, 1'b0);
      restart();
    end
    // Two retries with the fault held, then latched off
    wr(CMD_OV_ACTION, LEN_BYTE, 16'h0091, 1'b0);
    ovDetect = 1'b1;
    watch(100);
    chk_val(16'(ups), 16'h0002);
    chk_flag(outEnable, 1'b0);
    chk_flag(ovFault, 1'b1);
    restart();
    clr();
    // Endless retries
    wr(CMD_OV_ACTION, LEN_BYTE, 16'h00b9, 1'b0);
    ovDetect = 1'b1;
    watch(100);
    chk_flag(ups > 6, 1'b1);
    restart();
    clr();
    // Off only while the fault lasts
    wr(CMD_OV_ACTION, LEN_BYTE, 16'h00c0, 1'b0);
    ovDetect = 1'b1;
    step(10);
    chk_flag(outEnable, 1'b0);
    ovDetect = 1'b0;
    until_en(1'b1, 20);
    clr();
    // Delayed response: a short fault aborts, a long one disables late
    wr(CMD_OV_ACTION, LEN_BYTE, 16'h0041, 1'b0);
    ovDetect = 1'b1;
    step(1);
    ovDetect = 1'b0;
    watch(20);
    chk_val(16'(ups), 16'h0000);
    chk_flag(outEnable, 1'b1);
    clr();
    ovDetect = 1'b1;
    step(2);
    chk_flag(outEnable, 1'b1);
    step(10);
    chk_flag(outEnable, 1'b0);
    restart();
    clr();
    // Undervoltage: ignored, masked during ramp, then disable
    voutSample = lim - 16'h0001;
    step(20);
    chk_flag(uvFault, 1'b0);
    chk_flag(outEnable, 1'b1);
    rampActive = 1'b1;
    wr(CMD_UV_ACTION, LEN_BYTE, 16'h0080, 1'b0);
    step(20);
    chk_flag(uvFault, 1'b0);
    rampActive = 1'b0;
    step(5);
    chk_flag(uvFault, 1'b1);
    chk_flag(outEnable, 1'b0);
    outEnableReq = 1'b0;
    step(2);
    clr();
    step(10);
    chk_flag(uvFault, 1'b0);
    // Hold on undervoltage hiccups, since the mask frees it at once
    wr(CMD_UV_ACTION, LEN_BYTE, 16'h00c0, 1'b0);
    restart();
    watch(40);
    chk_flag(ups > 2, 1'b1);
    chk_flag(uvFault, 1'b1);
    voutSample = 16'hffff;
    restart();
    wrap_up();
  end
endmodule : tb_vofr_top
`default_nettype wire

/* test/vofr_host.sv */
// PMBus host model: issues decoded transactions on the command port.
// Assumes the supervisor answers cmdAck and cmdErr in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module vofr_host (
  // Clock
  input  wire logic        clk_sys,
  // Command port
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [1:0]       cmdLen,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdWrData,
  input  wire logic        cmdAck,
  input  wire logic        cmdErr
);
  // ==========================================================
  // Idle state
  initial begin
    cmdValid  = 1'b0;
    cmdWrite  = 1'b0;
    cmdLen    = 2'h3;
    cmdCode   = 8'hff;
    cmdWrData = 16'hffff;
  end

  // ==========================================================
  // One transaction, held until the acknowledging edge; code and data
  // then show the inverse so a stale value is never mistaken as live.
  // One idle edge follows, so valid never drops and rises in one step.
  task automatic issue(input logic wr, input logic [1:0] len,
                       input logic [7:0] code, input logic [15:0] data,
                       output logic err);
    cmdValid  = 1'b1;
    cmdWrite  = wr;
    cmdLen    = len;
    cmdCode   = code;
    cmdWrData = data;
    @(posedge clk_sys);
    err = (cmdAck === 1'b1) ? cmdErr : 1'bx;
    #1;
    cmdValid  = 1'b0;
    cmdCode   = ~code;
    cmdWrData = ~data;
    @(posedge clk_sys);
    #1;
  endtask : issue
endmodule : vofr_host
`default_nettype wire

/* verilog/vofr_pkg.sv */
// Shared constants of the output-voltage fault supervisor.
// Assumes a PMBus front end that hands over decoded transactions.

package vofr_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_ACTION    = 8'h41;
  localparam logic [7:0] CMD_UV_LIMIT     = 8'h44;
  localparam logic [7:0] CMD_UV_ACTION    = 8'h45;

  // ==========================================================
  // Transaction lengths on the command port
  localparam logic [1:0] LEN_SEND = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] OV_ACTION_RST = 8'h80;
  localparam logic [7:0] UV_ACTION_RST = 8'h80;

  // ==========================================================
  // Response byte layout
  localparam int BEH_HI   = 7;
  localparam int BEH_LO   = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int TIME_HI  = 2;
  localparam int TIME_LO  = 0;

  typedef enum logic [1:0] {
    BEH_IGNORE  = 2'h0,
    BEH_DELAY   = 2'h1,
    BEH_DISABLE = 2'h2,
    BEH_HOLD    = 2'h3
  } vofr_beh_t;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ==========================================================
  // Undervoltage default is strap times NUM over DEN
  localparam logic [17:0] UV_NUM = 18'h00004;
  localparam logic [17:0] UV_DEN = 18'h00005;

  // ==========================================================
  // Timing: one unit of the 3-bit time field per fault type
  localparam int CLK_NS     = 100;
  localparam int OV_UNIT_NS = 1000;
  localparam int UV_UNIT_NS = 10000;
  localparam int OV_UNIT_CYC = (OV_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_UNIT_CYC = (UV_UNIT_NS + CLK_NS - 1) / CLK_NS;

endpackage : vofr_pkg

/* verilog/vofr_resp.sv */
// Response engine for one fault type: delay, disable, retry, hold.
// Assumes faultNow is already masked where the fault type needs it.
`timescale 1ns/10ps
`default_nettype none

module vofr_resp #(
  parameter int UNIT_CYC   = 10,
  parameter bit CAN_IGNORE = 1'b1
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Setting and condition
  input  wire logic [7:0] action,
  input  wire logic       faultNow,
  input  wire logic       enableReq,
  // Response
  output logic            outOff,
  output logic            faultEvent
);
  import vofr_pkg::*;

  localparam int TW = $clog2(UNIT_CYC) + 1;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_DELAY = 5'h02,
    ST_OFF   = 5'h04,
    ST_HOLD  = 5'h08,
    ST_LATCH = 5'h10
  } vofr_state_t;

  vofr_state_t   state_ff, nxtState, disTarget;
  vofr_beh_t     beh, effBeh;
  logic [2:0]    retry, timeSet, usedCnt_ff, unitCnt_ff;
  logic [TW-1:0] tickCnt_ff;
  logic          react, exhausted, timerDone, tickWrap, timing, bump;

  // ==========================================================
  // Field decode
  assign beh     = vofr_beh_t'(action[BEH_HI:BEH_LO]);
  assign retry   = action[RETRY_HI:RETRY_LO];
  assign timeSet = action[TIME_HI:TIME_LO];
  // Ignore turns into plain disable where the fault may not be ignored
  assign effBeh  = (beh == BEH_IGNORE && !CAN_IGNORE) ?
                   BEH_DISABLE : beh;
  assign react   = enableReq && faultNow &&
                   (effBeh != BEH_IGNORE);
  assign exhausted = (retry != RETRY_FOREVER) &&
                     (usedCnt_ff >= retry);
  assign disTarget = exhausted ? ST_LATCH : ST_OFF;
  assign timerDone = (unitCnt_ff == timeSet);
  assign tickWrap  = (tickCnt_ff == TW'(UNIT_CYC - 1));
  assign timing    = (state_ff == ST_DELAY) || (state_ff == ST_OFF);
  assign bump      = (state_ff == ST_OFF) && timerDone &&
                     (retry != RETRY_FOREVER);

  // Next state; dropping the enable is a restart and wins
  always_comb begin
    nxtState = state_ff;
    if (!enableReq) begin
      nxtState = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (react) begin
            case (effBeh)
              BEH_DELAY: nxtState = ST_DELAY;
              BEH_HOLD:  nxtState = ST_HOLD;
              default:   nxtState = disTarget;
            endcase
          end
        end
        ST_DELAY: begin
          if (!faultNow) nxtState = ST_IDLE;
          else if (timerDone) nxtState = disTarget;
        end
        // Restart without looking at the fault; IDLE sees it again
        ST_OFF:   if (timerDone) nxtState = ST_IDLE;
        ST_HOLD:  if (!faultNow) nxtState = ST_IDLE;
        ST_LATCH: nxtState = ST_LATCH;
        default:  nxtState = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) state_ff <= ST_IDLE;
    else state_ff <= nxtState;
  end

  // Attempts used since the last restart
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) usedCnt_ff <= 3'h0;
    else if (!enableReq) usedCnt_ff <= 3'h0;
    else if (bump) usedCnt_ff <= 3'(usedCnt_ff + 3'h1);
  end

  // Unit timer restarts on every state change
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tickCnt_ff <= '0;
      unitCnt_ff <= 3'h0;
    end else if (!timing || state_ff != nxtState) begin
      tickCnt_ff <= '0;
      unitCnt_ff <= 3'h0;
    end else if (tickWrap) begin
      tickCnt_ff <= '0;
      if (!timerDone) unitCnt_ff <= 3'(unitCnt_ff + 3'h1);
    end else begin
      tickCnt_ff <= TW'(tickCnt_ff + 1'b1);
    end
  end

  assign outOff = (state_ff == ST_OFF) || (state_ff == ST_HOLD) ||
                  (state_ff == ST_LATCH);
  assign faultEvent = (state_ff == ST_IDLE) && react;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  hold_release_a: assert property (
    state_ff == ST_HOLD && enableReq && !faultNow |=> !outOff)
    else $error("hold did not release on fault clear");
  latch_stays_a: assert property (
    state_ff == ST_LATCH && enableReq |=> state_ff == ST_LATCH)
    else $error("latched off state left without restart");
  off_waits_a: assert property (
    state_ff == ST_OFF && !timerDone && enableReq
    |=> state_ff == ST_OFF)
    else $error("restart before retry time");
endmodule : vofr_resp

`default_nettype wire

/* verilog/vofr_top.sv */
// Output-voltage fault supervisor: response settings, UV threshold,
// UV comparison and sticky fault status behind the PMBus command port.
// Assumes a PMBus front end delivering one-cycle decoded transactions
// and an external overvoltage comparator.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Overvoltage fault can never be ignored
// - Overvoltage action resets to disable, no retry
// - Undervoltage action resets to disable, no retry
// - Behaviour 00 ignores the fault, keeps regulating
// - Behaviour 01 delays, disables, then retries
// - Behaviour 10 disables at once, then retries
// - Behaviour 11 holds off while OV persists; the UV mask frees it at once, so UV hiccups
// - Retry 000 stays off until restart
// - Retry 1..6 restarts that many, spaced
// - Retry 111 restarts forever without checking
// - Time field sets delay and retry spacing
// - Time unit depends on fault type
// - Fault status sticky until clear-faults command
// - UV compare masked during ramp or disable
// - UV limit word, default strap times 0.8
// - Response settings use byte transactions
module vofr_top #(
  parameter int OV_UNIT = vofr_pkg::OV_UNIT_CYC,
  parameter int UV_UNIT = vofr_pkg::UV_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Command port
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [1:0]  cmdLen,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWrData,
  output logic             cmdAck,
  output logic             cmdErr,
  output logic [15:0]      rdData,
  // Power stage
  input  wire logic        outEnableReq,
  input  wire logic        rampActive,
  input  wire logic        ovDetect,
  input  wire logic [15:0] voutSample,
  input  wire logic [15:0] strapVout,
  output logic             outEnable,
  // Status
  output logic             ovFault,
  output logic             uvFault
);
  import vofr_pkg::*;

  // ==========================================================
  // Default threshold scaling, also used by the checks
  function automatic logic [15:0] vofr_scale(input logic [15:0] s);
    logic [17:0] p;
    p = 18'(s) * UV_NUM;
    return 16'(p / UV_DEN);
  endfunction : vofr_scale

  // ==========================================================
  // State
  logic [7:0]  ovAct_ff;
  logic [7:0]  uvAct_ff;
  logic [15:0] uvLim_ff;
  logic        uvLoaded_ff;
  logic        ovFault_ff;
  logic        uvFault_ff;
  logic        outEnable_ff;
  logic [15:0] rdData_ff;

  logic [15:0] nxt_rdData;
  logic        nxt_outEnable;
  logic        nxt_ovFault;
  logic        nxt_uvFault;

  // ==========================================================
  // Command decode
  logic hitOvAct;
  logic hitUvAct;
  logic hitUvLim;
  logic hitClear;
  logic legal;
  logic isRead;
  logic ovActWr;
  logic uvActWr;
  logic uvLimWr;
  logic clearCmd;

  // Byte settings only by byte, limit only by word
  assign hitOvAct = (cmdCode == CMD_OV_ACTION) &&
                    (cmdLen == LEN_BYTE);
  assign hitUvAct = (cmdCode == CMD_UV_ACTION) &&
                    (cmdLen == LEN_BYTE);
  assign hitUvLim = (cmdCode == CMD_UV_LIMIT) &&
                    (cmdLen == LEN_WORD);
  assign hitClear = (cmdCode == CMD_CLEAR_FAULTS) &&
                    (cmdLen == LEN_SEND) && cmdWrite;
  assign legal    = hitOvAct || hitUvAct || hitUvLim || hitClear;
  assign isRead   = cmdValid && !cmdWrite && legal;
  assign ovActWr  = cmdValid && cmdWrite && hitOvAct;
  assign uvActWr  = cmdValid && cmdWrite && hitUvAct;
  assign uvLimWr  = cmdValid && cmdWrite && hitUvLim;
  assign clearCmd = cmdValid && hitClear;

  // Every transaction is answered at once; wrong ones are flagged
  assign cmdAck = cmdValid;
  assign cmdErr = cmdValid && !legal;

  // Read data mux; narrow settings sit in the low byte
  always_comb begin
    nxt_rdData = rdData_ff;
    if (isRead) begin
      if (hitOvAct) nxt_rdData = {8'h00, ovAct_ff};
      else if (hitUvAct) nxt_rdData = {8'h00, uvAct_ff};
      else nxt_rdData = uvLim_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rdData_ff <= 16'h0000;
    else rdData_ff <= nxt_rdData;
  end

  // ==========================================================
  // Response settings
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovAct_ff <= OV_ACTION_RST;
      uvAct_ff <= UV_ACTION_RST;
    end else begin
      if (ovActWr) ovAct_ff <= cmdWrData[7:0];
      if (uvActWr) uvAct_ff <= cmdWrData[7:0];
    end
  end

  // ==========================================================
  // UV threshold: the strap is a live pin, so it is caught on the
  // first clock after reset instead of inside the reset branch.
  // Range against the output maximum is the host's duty.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      uvLim_ff    <= 16'h0000;
      uvLoaded_ff <= 1'b0;
    end else begin
      uvLoaded_ff <= 1'b1;
      if (uvLimWr) uvLim_ff <= cmdWrData;
      else if (!uvLoaded_ff) uvLim_ff <= vofr_scale(strapVout);
    end
  end

  // ==========================================================
  // Fault conditions
  logic ovFaultNow;
  logic uvFaultNow;
  logic ovOff;
  logic uvOff;
  logic ovEvent;
  logic uvEvent;

  assign ovFaultNow = ovDetect;
  // No UV while ramping or off, else every start would trip
  assign uvFaultNow = outEnable_ff && outEnableReq && !rampActive &&
                      (voutSample < uvLim_ff);

  // Separate engines so each fault uses its own time unit
  vofr_resp #(
    .UNIT_CYC   (OV_UNIT),
    .CAN_IGNORE (1'b0)
  ) u_ov (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .action     (ovAct_ff),
    .faultNow   (ovFaultNow),
    .enableReq  (outEnableReq),
    .outOff     (ovOff),
    .faultEvent (ovEvent)
  );

  vofr_resp #(
    .UNIT_CYC   (UV_UNIT),
    .CAN_IGNORE (1'b1)
  ) u_uv (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .action     (uvAct_ff),
    .faultNow   (uvFaultNow),
    .enableReq  (outEnableReq),
    .outOff     (uvOff),
    .faultEvent (uvEvent)
  );

  // ==========================================================
  // Output enable and sticky status; a new event beats a clear
  assign nxt_outEnable = outEnableReq && !ovOff && !uvOff;
  assign nxt_ovFault = ovEvent || (ovFault_ff && !clearCmd);
  assign nxt_uvFault = uvEvent || (uvFault_ff && !clearCmd);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      outEnable_ff <= 1'b0;
      ovFault_ff   <= 1'b0;
      uvFault_ff   <= 1'b0;
    end else begin
      outEnable_ff <= nxt_outEnable;
      ovFault_ff   <= nxt_ovFault;
      uvFault_ff   <= nxt_uvFault;
    end
  end

  assign outEnable = outEnable_ff;
  assign ovFault   = ovFault_ff;
  assign uvFault   = uvFault_ff;
  assign rdData    = rdData_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ov_no_ignore_a: assert property (
    outEnable_ff && outEnableReq && ovDetect &&
    ovAct_ff[BEH_HI:BEH_LO] == BEH_IGNORE
    |=> ovFault_ff ##1 !outEnable_ff)
    else $error("ignore took effect on overvoltage");

  ov_reset_val_a: assert property (
    !uvLoaded_ff |-> ovAct_ff == OV_ACTION_RST)
    else $error("overvoltage action reset value wrong");

  uv_reset_val_a: assert property (
    !uvLoaded_ff |-> uvAct_ff == UV_ACTION_RST)
    else $error("undervoltage action reset value wrong");

  uv_ignore_a: assert property (
    uvAct_ff[BEH_HI:BEH_LO] == BEH_IGNORE |-> !uvEvent)
    else $error("ignored undervoltage raised an event");

  delay_first_a: assert property (
    ovEvent && ovAct_ff[BEH_HI:BEH_LO] == BEH_DELAY &&
    ovAct_ff[TIME_HI:TIME_LO] != 3'h0 |=> !ovOff)
    else $error("delayed response disabled at once");

  off_at_once_a: assert property (
    ovEvent && ovAct_ff[BEH_HI:BEH_LO] == BEH_DISABLE
    |=> ovOff ##1 !outEnable_ff)
    else $error("disable response not immediate");

  status_sticky_a: assert property (
    (ovFault_ff && !clearCmd) or ovEvent |=> ovFault_ff)
    else $error("fault status lost without clear");

  uv_masked_a: assert property (
    rampActive || !outEnable_ff |-> !uvEvent)
    else $error("undervoltage raised while masked");

  uv_default_a: assert property (
    $rose(uvLoaded_ff) && !$past(uvLimWr)
    |-> uvLim_ff == vofr_scale($past(strapVout)))
    else $error("undervoltage default not scaled strap");

  setting_wr_a: assert property (
    uvActWr |=> uvAct_ff == $past(cmdWrData[7:0]))
    else $error("byte write did not land");

  delay_path_c: cover property (
    ovEvent && ovAct_ff[BEH_HI:BEH_LO] == BEH_DELAY ##[1:200] ovOff);
  uv_hold_c: cover property (
    uvEvent && uvAct_ff[BEH_HI:BEH_LO] == BEH_HOLD);
  clear_c: cover property (ovFault_ff && clearCmd ##1 !ovFault_ff);

endmodule : vofr_top

`default_nettype wire
